// ==== core/call_handshake_pkg.sv ====
// shared widths, state encoding and carrier types of the call handshake block
package call_handshake_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int DATA_W = 32;

  // ------------------------------------------------------------------
  // build options
  // ------------------------------------------------------------------
  localparam bit HAS_CHIP_ENABLE = 1'b1;
  localparam bit KERNEL_VARIANT  = 1'b0;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef logic [DATA_W-1:0] word_t;

  typedef enum logic [2:0] {
    WAIT_LAUNCH,
    FETCH,
    CALC,
    FINISH,
    RETIRE
  } phase_t;

  typedef struct packed {
    word_t in_a;
    word_t in_b;
    word_t accum_in;
  } args_in_t;

  typedef struct packed {
    phase_t fsm;
    word_t  a;
    word_t  b;
    word_t  acc;
    word_t  sum_ab;
    word_t  accum_out;
    logic   accum_vld;
    word_t  result;
    logic   done;
    logic   consumed;
    logic   quiescent;
  } core_state_t;

  localparam word_t WORD_ZERO = 32'h0000_0000;

endpackage : call_handshake_pkg

// ==== core/call_handshake.sv ====
// call handshake block: launch/complete control plus argument ports of an adder call
//
// Contract
// - The controller raises launch_request to start a call and the block starts on seeing it.
// - block_quiescent stays low for the whole time a call is being processed.
// - Input arguments are sampled after the first cycle of the call, on a fixed schedule.
// - inputs_consumed goes high once every input argument of the call has been sampled.
// - transaction_complete marks the end of a call and result_value is valid at that moment.
// - After a call completes, block_quiescent goes high to show it waits for a new launch.
// - The output pointer argument has a data port plus a valid strobe marking readable cycles.
// - A read-and-written argument becomes an input port and an output port with its own strobe.
// - The function return value leaves through a dedicated result_value output port.
// - Pass-by-value and input pointer arguments are plain data wires with no handshake.
// - The block has one clock and one reset besides its control and argument ports.
// - An optional chip enable input gates the operation of the whole block.
// - Launch, consumed, quiescent and complete control the block apart from argument handshakes.
// - Argument ports move data only after the launch handshake has started the call.
// - The kernel variant (scalars and control in one AXI4-Lite slave, arrays in AXI4) is a separate build; KERNEL raises an elaboration error.
module call_handshake #(
  parameter int DATA_WIDTH = call_handshake_pkg::DATA_W,
  parameter bit USE_CE     = call_handshake_pkg::HAS_CHIP_ENABLE,
  parameter bit KERNEL     = call_handshake_pkg::KERNEL_VARIANT
) (
  // clock and reset
  input  wire logic                      CLOCK,
  input  wire logic                      RST_B,
  // block enable
  input  wire logic                      CHIP_ENABLE,
  // block-level control
  input  wire logic                      LAUNCH_REQUEST,
  output logic                           INPUTS_CONSUMED,
  output logic                           BLOCK_QUIESCENT,
  output logic                           TRANSACTION_COMPLETE,
  // argument inputs, no handshake
  input  wire call_handshake_pkg::args_in_t ARGS_IN,
  // in/out argument, output half
  output call_handshake_pkg::word_t      ACCUM_OUT,
  output logic                           ACCUM_OUT_VALID,
  // return value
  output call_handshake_pkg::word_t      RESULT_VALUE
);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  // carriers are fixed-width structs, so the width cannot float
  if (DATA_WIDTH != call_handshake_pkg::DATA_W) begin : g_bad_width
    $error("DATA_WIDTH must equal the package word width");
  end
  // the bus-wrapped form is a different build of this block, not served here
  if (KERNEL) begin : g_bad_variant
    $error("kernel variant needs the AXI4-Lite and AXI4 wrapper build");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  call_handshake_pkg::core_state_t st;
  call_handshake_pkg::core_state_t next_st;
  logic                            run;

  // without the option the enable pin is ignored entirely
  assign run = USE_CE ? CHIP_ENABLE : 1'b1;

  function automatic call_handshake_pkg::word_t add2(
    input call_handshake_pkg::word_t x,
    input call_handshake_pkg::word_t y
  );
    add2 = call_handshake_pkg::word_t'(x + y);
  endfunction : add2

  always_comb begin
    next_st = st;
    if (run) begin
      next_st.consumed  = 1'b0;
      next_st.accum_vld = 1'b0;
      next_st.done      = 1'b0;
      case (st.fsm)
        call_handshake_pkg::WAIT_LAUNCH: begin
          if (LAUNCH_REQUEST) begin
            next_st.fsm       = call_handshake_pkg::FETCH;
            next_st.quiescent = 1'b0;
          end
        end
        call_handshake_pkg::FETCH: begin
          // plain wires sampled on the second cycle; caller must hold them until now
          next_st.a        = ARGS_IN.in_a;
          next_st.b        = ARGS_IN.in_b;
          next_st.acc      = ARGS_IN.accum_in;
          next_st.consumed = 1'b1;
          next_st.fsm      = call_handshake_pkg::CALC;
        end
        call_handshake_pkg::CALC: begin
          next_st.sum_ab    = add2(st.a, st.b);
          next_st.accum_out = add2(add2(st.a, st.b), st.acc);
          next_st.accum_vld = 1'b1;
          next_st.fsm       = call_handshake_pkg::FINISH;
        end
        call_handshake_pkg::FINISH: begin
          next_st.result = st.sum_ab;
          next_st.done   = 1'b1;
          next_st.fsm    = call_handshake_pkg::RETIRE;
        end
        call_handshake_pkg::RETIRE: begin
          next_st.quiescent = 1'b1;
          next_st.fsm       = call_handshake_pkg::WAIT_LAUNCH;
        end
        default: begin
          next_st.fsm       = call_handshake_pkg::WAIT_LAUNCH;
          next_st.quiescent = 1'b1;
        end
      endcase
    end
  end

  // single clock, single reset
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      st.fsm       <= call_handshake_pkg::WAIT_LAUNCH;
      st.a         <= call_handshake_pkg::WORD_ZERO;
      st.b         <= call_handshake_pkg::WORD_ZERO;
      st.acc       <= call_handshake_pkg::WORD_ZERO;
      st.sum_ab    <= call_handshake_pkg::WORD_ZERO;
      st.accum_out <= call_handshake_pkg::WORD_ZERO;
      st.accum_vld <= 1'b0;
      st.result    <= call_handshake_pkg::WORD_ZERO;
      st.done      <= 1'b0;
      st.consumed  <= 1'b0;
      st.quiescent <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all straight from flops
  // ------------------------------------------------------------------
  assign INPUTS_CONSUMED      = st.consumed;
  assign BLOCK_QUIESCENT      = st.quiescent;
  assign TRANSACTION_COMPLETE = st.done;
  assign ACCUM_OUT            = st.accum_out;
  assign ACCUM_OUT_VALID      = st.accum_vld;
  assign RESULT_VALUE         = st.result;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  // timing figures below hold while the enable stays high; stalls are checked apart
  property p_launch_leaves_quiet;
    @(posedge CLOCK) disable iff (!RST_B || !run)
    BLOCK_QUIESCENT && LAUNCH_REQUEST |=> !BLOCK_QUIESCENT;
  endproperty
  a_launch_leaves_quiet: assert property (p_launch_leaves_quiet)
    else $error("launch did not take the block out of quiescence");

  property p_busy_span;
    @(posedge CLOCK) disable iff (!RST_B || !run)
    $fell(BLOCK_QUIESCENT) |-> !BLOCK_QUIESCENT [*4] ##1 BLOCK_QUIESCENT;
  endproperty
  a_busy_span: assert property (p_busy_span)
    else $error("quiescent flag wrong during a call");

  property p_sample_point;
    @(posedge CLOCK) disable iff (!RST_B || !run)
    st.fsm == call_handshake_pkg::FETCH |=> st.a == $past(ARGS_IN.in_a)
      && st.b == $past(ARGS_IN.in_b)
      && st.acc == $past(ARGS_IN.accum_in);
  endproperty
  a_sample_point: assert property (p_sample_point)
    else $error("inputs not sampled on the second cycle of the call");

  property p_consumed_timing;
    @(posedge CLOCK) disable iff (!RST_B || !run)
    $fell(BLOCK_QUIESCENT) |=> INPUTS_CONSUMED ##1 !INPUTS_CONSUMED;
  endproperty
  a_consumed_timing: assert property (p_consumed_timing)
    else $error("inputs_consumed not one cycle after launch");

  property p_result_at_done;
    @(posedge CLOCK) disable iff (!RST_B)
    TRANSACTION_COMPLETE |-> RESULT_VALUE == add2(st.a, st.b);
  endproperty
  a_result_at_done: assert property (p_result_at_done)
    else $error("result not valid with completion");

  property p_quiet_after_done;
    @(posedge CLOCK) disable iff (!RST_B || !run)
    TRANSACTION_COMPLETE |=> BLOCK_QUIESCENT && !TRANSACTION_COMPLETE;
  endproperty
  a_quiet_after_done: assert property (p_quiet_after_done)
    else $error("block not quiescent after completion");

  property p_accum_value;
    @(posedge CLOCK) disable iff (!RST_B)
    ACCUM_OUT_VALID |-> ACCUM_OUT == add2(add2(st.a, st.b), st.acc);
  endproperty
  a_accum_value: assert property (p_accum_value)
    else $error("accumulator output wrong while valid");

  property p_strobe_then_done;
    @(posedge CLOCK) disable iff (!RST_B || !run)
    ACCUM_OUT_VALID |=> !ACCUM_OUT_VALID && TRANSACTION_COMPLETE;
  endproperty
  a_strobe_then_done: assert property (p_strobe_then_done)
    else $error("valid strobe not a single cycle before completion");

  property p_ports_inside_call;
    @(posedge CLOCK) disable iff (!RST_B)
    INPUTS_CONSUMED || ACCUM_OUT_VALID || TRANSACTION_COMPLETE |-> !BLOCK_QUIESCENT;
  endproperty
  a_ports_inside_call: assert property (p_ports_inside_call)
    else $error("argument activity outside a launched call");

  property p_enable_freezes;
    @(posedge CLOCK) disable iff (!RST_B)
    !run |=> $stable(st);
  endproperty
  a_enable_freezes: assert property (p_enable_freezes)
    else $error("block moved while chip enable low");

  property p_launch_needs_request;
    @(posedge CLOCK) disable iff (!RST_B)
    $fell(BLOCK_QUIESCENT) |-> $past(LAUNCH_REQUEST);
  endproperty
  a_launch_needs_request: assert property (p_launch_needs_request)
    else $error("block left quiescence without a launch request");

  property p_busy_until_done;
    @(posedge CLOCK) disable iff (!RST_B || !run)
    !BLOCK_QUIESCENT && !TRANSACTION_COMPLETE |=> !BLOCK_QUIESCENT;
  endproperty
  a_busy_until_done: assert property (p_busy_until_done)
    else $error("quiescent rose before completion");

  // only the fetch step may load the argument registers
  property p_args_held;
    @(posedge CLOCK) disable iff (!RST_B)
    st.fsm != call_handshake_pkg::FETCH |=> $stable(st.a) && $stable(st.b)
      && $stable(st.acc);
  endproperty
  a_args_held: assert property (p_args_held)
    else $error("argument registers loaded outside the fetch step");

  property p_consumed_single;
    @(posedge CLOCK) disable iff (!RST_B || !run)
    INPUTS_CONSUMED |=> !INPUTS_CONSUMED && ACCUM_OUT_VALID;
  endproperty
  a_consumed_single: assert property (p_consumed_single)
    else $error("inputs_consumed not a single cycle before the strobe");

  property p_result_only_at_done;
    @(posedge CLOCK) disable iff (!RST_B)
    $changed(RESULT_VALUE) |-> TRANSACTION_COMPLETE;
  endproperty
  a_result_only_at_done: assert property (p_result_only_at_done)
    else $error("result moved outside a completion");

  property p_idle_waits;
    @(posedge CLOCK) disable iff (!RST_B || !run)
    BLOCK_QUIESCENT && !LAUNCH_REQUEST |=> BLOCK_QUIESCENT;
  endproperty
  a_idle_waits: assert property (p_idle_waits)
    else $error("block left quiescence with no launch");

  property p_quiet_needs_done;
    @(posedge CLOCK) disable iff (!RST_B)
    $rose(BLOCK_QUIESCENT) |-> $past(TRANSACTION_COMPLETE);
  endproperty
  a_quiet_needs_done: assert property (p_quiet_needs_done)
    else $error("quiescent rose without a completion");

  property p_accum_only_with_strobe;
    @(posedge CLOCK) disable iff (!RST_B)
    $changed(ACCUM_OUT) |-> ACCUM_OUT_VALID;
  endproperty
  a_accum_only_with_strobe: assert property (p_accum_only_with_strobe)
    else $error("accumulator output moved without its strobe");

  property p_accum_matches_result;
    @(posedge CLOCK) disable iff (!RST_B)
    TRANSACTION_COMPLETE |-> ACCUM_OUT == add2(RESULT_VALUE, st.acc);
  endproperty
  a_accum_matches_result: assert property (p_accum_matches_result)
    else $error("accumulator output not return value plus accumulator input");

  // reset itself is the trigger here, so no disable clause
  property p_reset_state;
    @(posedge CLOCK)
    !RST_B |=> BLOCK_QUIESCENT && !INPUTS_CONSUMED && !ACCUM_OUT_VALID
      && !TRANSACTION_COMPLETE;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("outputs not at reset values");

  c_launch: cover property (@(posedge CLOCK) disable iff (!RST_B)
    BLOCK_QUIESCENT && LAUNCH_REQUEST && run);
  c_full_call: cover property (@(posedge CLOCK) disable iff (!RST_B)
    $fell(BLOCK_QUIESCENT) ##[3:20] TRANSACTION_COMPLETE);
  c_stall_mid_call: cover property (@(posedge CLOCK) disable iff (!RST_B)
    !BLOCK_QUIESCENT && !run);
  c_back_to_back: cover property (@(posedge CLOCK) disable iff (!RST_B)
    TRANSACTION_COMPLETE ##2 $fell(BLOCK_QUIESCENT));
  c_refused_launch: cover property (@(posedge CLOCK) disable iff (!RST_B)
    !BLOCK_QUIESCENT && LAUNCH_REQUEST && run);

endmodule : call_handshake

// ==== verification/call_controller.sv ====
// upstream controller model: launches calls and drives the plain argument wires
module call_controller (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  // block-level control
  input  wire logic                          chip_enable,
  input  wire logic                          block_quiescent,
  input  wire logic                          inputs_consumed,
  output logic                               launch_request,
  // argument wires
  output call_handshake_pkg::args_in_t       args_in
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    launch_request = 1'b0;
    args_in = '1;
  end

  // gap adds idle cycles before the request
  task automatic call(input call_handshake_pkg::args_in_t a, input int gap);
    bit taken;
    repeat (gap + 1) @(negedge clock);
    launch_request = 1'b1;
    args_in = a;
    taken = 1'b0;
    while (!taken) begin
      @(posedge clock);
      taken = block_quiescent && chip_enable && rst_b;
    end
    @(negedge clock);
    launch_request = 1'b0;
    do @(posedge clock); while (inputs_consumed !== 1'b1);
    @(negedge clock);
    // wires no longer held: show stale data rather than a frozen value
    args_in = ~a;
  endtask : call
endmodule : call_controller

// ==== verification/call_handshake_bench.sv ====
// self-checking bench of the call handshake block
module call_handshake_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    call_handshake_pkg::word_t acc;
    call_handshake_pkg::word_t ret;
  } expect_t;

  logic                         clock;
  logic                         rst_b;
  logic                         chip_enable;
  logic                         launch_request;
  logic                         inputs_consumed;
  logic                         block_quiescent;
  logic                         transaction_complete;
  logic                         accum_out_valid;
  logic                         moved;
  call_handshake_pkg::args_in_t args_in;
  call_handshake_pkg::word_t    accum_out;
  call_handshake_pkg::word_t    result_value;
  expect_t                      notes[$];
  int                           bad_count;
  int                           n_compared;
  int                           age;
  int                           cycles;

  call_handshake i_dut (.CLOCK(clock), .RST_B(rst_b), .CHIP_ENABLE(chip_enable),
    .LAUNCH_REQUEST(launch_request), .INPUTS_CONSUMED(inputs_consumed),
    .BLOCK_QUIESCENT(block_quiescent), .TRANSACTION_COMPLETE(transaction_complete),
    .ARGS_IN(args_in), .ACCUM_OUT(accum_out), .ACCUM_OUT_VALID(accum_out_valid),
    .RESULT_VALUE(result_value));

  call_controller i_ctrl (.clock(clock), .rst_b(rst_b), .chip_enable(chip_enable),
    .block_quiescent(block_quiescent), .inputs_consumed(inputs_consumed),
    .launch_request(launch_request), .args_in(args_in));

  // ------------------------------------------------------------------
  // compare and closing
  // ------------------------------------------------------------------
  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_word(input call_handshake_pkg::word_t got, exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic launch_call(input call_handshake_pkg::args_in_t a, input int gap);
    notes.push_back({a.in_a + a.in_b + a.accum_in, a.in_a + a.in_b});
    i_ctrl.call(a, gap);
  endtask : launch_call

  task automatic drain(input string name);
    for (int k = 0; k < 40 && notes.size() != 0; k++) @(negedge clock);
    if (notes.size() != 0) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, notes.size(), 0);
    end
    repeat (2) @(negedge clock);
    $display("test %s done", name);
  endtask : drain

  // ------------------------------------------------------------------
  // clock, timeout, result monitor
  // ------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      conclude();
    end
  end

  // age counts cycles since the launch was taken; frozen by chip enable
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      age <= 0;
      moved <= 1'b0;
    end else begin
      moved <= chip_enable;
      if (chip_enable && launch_request && block_quiescent) age <= 1;
      else if (chip_enable && age != 0) age <= (age == 4) ? 0 : age + 1;
    end
  end

  always @(negedge clock) if (rst_b === 1'b1) begin
    check_bit(block_quiescent, age == 0);
    check_bit(inputs_consumed, age == 2);
    check_bit(accum_out_valid, age == 3);
    check_bit(transaction_complete, age == 4);
    if (moved && age == 3) check_word(accum_out, notes[0].acc);
    if (moved && age == 4) begin
      check_word(result_value, notes[0].ret);
      void'(notes.pop_front());
    end
  end

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    chip_enable = 1'b1;
    void'($urandom(32'hF2EA));
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst_b = 1'b1;
    for (int i = 0; i < 4; i++) launch_call({$urandom, $urandom, $urandom}, i * 2);
    drain("slow");
    for (int i = 0; i < 4; i++) launch_call({$urandom, $urandom, $urandom}, 0);
    drain("back_to_back");
    launch_call({32'hFFFF_FFFF, 32'h0000_0001, 32'hFFFF_FFFF}, 0);
    launch_call({32'h8000_0000, 32'h8000_0000, 32'h0000_0000}, 0);
    drain("wrap");
    for (int d = 1; d < 4; d += 2) fork
      launch_call({$urandom, $urandom, $urandom}, 0);
      begin
        repeat (d) @(negedge clock);
        chip_enable = 1'b0;
        repeat (3) @(negedge clock);
        chip_enable = 1'b1;
      end
    join
    drain("chip_enable");
    conclude();
  end
endmodule : call_handshake_bench
